// ==== logic/drive_profile_defines.vh ====
// Constants for the drive profile word interpreter
`ifndef DRIVE_PROFILE_DEFINES_VH
`define DRIVE_PROFILE_DEFINES_VH
// Control word bit positions
`define CW_ON 0
`define CW_NO_COAST 1
`define CW_NO_QUICK 2
`define CW_ENABLE_OP 3
`define CW_RAMP_RUN 5
`define CW_SETPOINT_EN 6
`define CW_FAULT_ACK 7
`define CW_PLC_CTRL 10
`define CW_TORQUE_EN 11
`define CW_DIR_INV 12
`define CW_HOMING 13
// Signal numbers for mapping slots
`define SIG_UNASSIGNED 16'h270F
`define SIG_SPEED_SET 16'h0005
`define SIG_TORQUE_SET 16'h0064
`define SIG_SPEED_ACT 16'h0006
`define SIG_TORQUE_ACT 16'h0065
// Speed reference and torque clamp
`define SPEED_REF_SHIFT 14
`define TORQUE_MAX 16'sh0190
`define TORQUE_MIN -16'sh0190
// Fault acknowledge hold time
`define FAULT_ACK_MS 20
`define CLK_KHZ 250000
`define FAULT_ACK_CYCLES (`FAULT_ACK_MS * `CLK_KHZ)
// Drive states
`define ST_INHIBIT 3'h0
`define ST_READY 3'h1
`define ST_SWITCHED_ON 3'h2
`define ST_OPERATION 3'h3
`define ST_QUICK_STOP 3'h4
`endif

// ==== logic/drive_profile_word_interpreter.v ====
// Drive profile word interpreter with setpoint FIFO
`timescale 1ns/10ps
`default_nettype none
`include "drive_profile_defines.vh"

// Setpoint FIFO, parameterised width and depth
module setpoint_fifo #(
  parameter WIDTH = 48,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire core_clk,
  input wire rst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0] wr_q;
  reg [AW:0] rd_q;
  // One spare pointer bit tells full from empty
  wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
  wire empty = (wr_q == rd_q);
  // Head word shows without a wait; valid follows the pointers
  assign in_ready = !full;
  assign out_valid = !empty;
  assign out_data = mem[rd_q[AW-1:0]];
  // Storage has no reset; pointers define validity
  always @(posedge core_clk) begin
    if (in_valid && !full) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  // Pointer update
  // Push and pop may fall in one cycle
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && !full) begin
        wr_q <= wr_q + 1'b1;
      end
      if (out_ready && !empty) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end
endmodule // setpoint_fifo

// Contract
// RULE1 - Duplicate setpoint numbers: lowest slot wins
// RULE2 - Unknown or unassigned slots write nothing, read zero
// RULE3 - Bits 0,2,3: on, quick stop, enable
// RULE4 - Bit 1 low forces coast stop
// RULE5 - Bit 5 low freezes ramp while running; the code does not freeze it under position control
// RULE6 - Bit 6 low forces speed setpoint zero
// RULE7 - Bit 7 held 20 ms clears faults
// RULE8 - Bit 10 low ignores control word
// RULE9 - Bit 11 low forces torque zero
// RULE10 - Bit 12 inverts direction; torque uses magnitude
// RULE11 - Bit 13 homing only in position, operation
// RULE12 - Master zeros unused bits; device zeros status
// RULE13 - Status bits 0,1,2,6 show drive state
// RULE14 - Status bit 3 shows fault present
// RULE15 - Status bit 4 low during coast stop
// RULE16 - Status bit 5 low during quick stop
// RULE17 - Status bit 7 shows warning present
// RULE18 - Status bit 9 shows network control
// RULE19 - Frequency equals word over 4000h times max
// RULE20 - Speed words signed 16-bit, 16384 full scale
// RULE21 - Target torque clamped to plus minus 400
// RULE22 - Torque in 1%, actual in 0.1%
// RULE23 - Power-up in inhibited state, output off
// RULE24 - Status and actuals refreshed every exchange
module drive_profile_word_interpreter #(
  parameter SLOTS = 10,
  parameter ACT_SLOTS = 14,
  parameter FREQ_W = 16,
  parameter FIFO_DEPTH = 16,
  parameter FAULT_ACK_CYCLES = `FAULT_ACK_CYCLES
) (
  input wire core_clk,
  input wire rst,
  input wire rx_valid,
  output wire rx_ready,
  input wire [15:0] control_word,
  input wire [SLOTS*32-1:0] rx_slot_data,
  input wire [SLOTS*16-1:0] setpoint_map_slot,
  input wire [ACT_SLOTS*16-1:0] actual_map_slot,
  input wire [FREQ_W-1:0] max_frequency,
  input wire network_op_mode,
  input wire position_control,
  input wire fault_active,
  input wire warning_active,
  input wire [15:0] fault_number_record,
  input wire motor_stopped,
  input wire signed [15:0] speed_actual_in,
  input wire signed [15:0] motor_torque_monitor,
  output reg tx_valid,
  output reg [15:0] status_word,
  output reg [ACT_SLOTS*32-1:0] tx_slot_data,
  output reg [FREQ_W-1:0] set_frequency,
  output reg run_reverse,
  output reg start_cmd,
  output reg output_enable,
  output reg ramp_freeze,
  output reg quick_stop_active,
  output reg signed [15:0] torque_command_value,
  output reg homing_start,
  output reg fault_reset,
  output reg [FREQ_W-1:0] output_frequency
);
  // Setpoint frame queued so bursts from the master are not lost
  wire f_valid;
  wire [47:0] f_data;
  reg f_ready;
  // Slot resolution results feed the queue, so they are declared first
  reg [15:0] speed_sel;
  reg [15:0] torque_sel;
  reg speed_hit;
  reg torque_hit;
  reg torque_mapped;
  setpoint_fifo #(.WIDTH(48), .DEPTH(FIFO_DEPTH), .AW($clog2(FIFO_DEPTH))) u_fifo (
    .core_clk(core_clk),
    .rst(rst),
    .in_valid(rx_valid),
    .in_ready(rx_ready),
    .in_data({control_word, speed_sel, torque_sel}),
    .out_valid(f_valid),
    .out_ready(f_ready),
    .out_data(f_data)
  );

  // Resolve setpoint slots; first match wins, later duplicates ignored
  // Lower slot index stands for the lower parameter number
  integer i;
  always @* begin
    speed_sel = 16'h0000;
    torque_sel = 16'h0000;
    speed_hit = 1'b0;
    torque_hit = 1'b0;
    for (i = 0; i < SLOTS; i = i + 1) begin
      if (!speed_hit && setpoint_map_slot[i*16 +: 16] == `SIG_SPEED_SET) begin // RULE1
        speed_sel = rx_slot_data[i*32 +: 16];
        speed_hit = 1'b1;
      end
      if (!torque_hit && setpoint_map_slot[i*16 +: 16] == `SIG_TORQUE_SET) begin // RULE1
        torque_sel = rx_slot_data[i*32 +: 16];
        torque_hit = 1'b1;
      end
    end
    torque_mapped = torque_hit;
  end

  // Hold last written values when a signal is unmapped
  // Registered to line up with the frame leaving the queue
  reg speed_map_q;
  reg torque_map_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      speed_map_q <= 1'b0;
      torque_map_q <= 1'b0;
    end else begin
      speed_map_q <= speed_hit;
      torque_map_q <= torque_mapped;
    end
  end

  // Frame fields out of the FIFO
  wire [15:0] cw = f_data[47:32];
  wire signed [15:0] spd_in = f_data[31:16];
  wire signed [15:0] trq_in = f_data[15:0];
  // Queue pops every cycle, so each frame is taken one edge after entry
  wire take = f_valid;
  wire plc = cw[`CW_PLC_CTRL] && network_op_mode; // RULE8

  // Drive state machine
  reg [2:0] state_q;
  reg [2:0] state_d;
  always @* begin
    f_ready = 1'b1;
    state_d = state_q;
    // Faults and local operation pull the drive back to inhibited
    if (fault_active || !network_op_mode) begin
      state_d = `ST_INHIBIT;
    end else if (take && plc) begin // RULE8
      case (state_q)
        `ST_INHIBIT: begin
          if (cw[`CW_NO_COAST] && cw[`CW_NO_QUICK] && !cw[`CW_ON]) state_d = `ST_READY; // RULE3
        end
        `ST_READY: begin
          if (!cw[`CW_NO_COAST] || !cw[`CW_NO_QUICK]) state_d = `ST_INHIBIT; // RULE4
          else if (cw[`CW_ON]) state_d = `ST_SWITCHED_ON; // RULE3
        end
        `ST_SWITCHED_ON: begin
          if (!cw[`CW_NO_COAST] || !cw[`CW_NO_QUICK]) state_d = `ST_INHIBIT; // RULE4
          else if (!cw[`CW_ON]) state_d = `ST_READY; // RULE3
          else if (cw[`CW_ENABLE_OP]) state_d = `ST_OPERATION; // RULE3
        end
        `ST_OPERATION: begin
          if (!cw[`CW_NO_COAST]) state_d = `ST_INHIBIT; // RULE4
          else if (!cw[`CW_NO_QUICK]) state_d = `ST_QUICK_STOP; // RULE3
          else if (!cw[`CW_ON]) state_d = `ST_READY;
          else if (!cw[`CW_ENABLE_OP]) state_d = `ST_SWITCHED_ON; // RULE3
        end
        `ST_QUICK_STOP: begin
          if (!cw[`CW_NO_COAST]) state_d = `ST_INHIBIT; // RULE4
        end
        default: state_d = `ST_INHIBIT;
      endcase
    end
    // Quick stop ends once the motor has stopped, master or not
    if (state_q == `ST_QUICK_STOP && motor_stopped && !fault_active) begin
      state_d = `ST_INHIBIT;
    end
  end

  // Latched control bits from last accepted word
  reg [15:0] cw_q;
  reg signed [15:0] spd_q;
  reg signed [15:0] trq_q;
  // Power-up leaves the drive inhibited with outputs off
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= `ST_INHIBIT; // RULE23
      cw_q <= 16'h0000;
      spd_q <= 16'sh0000;
      trq_q <= 16'sh0000;
    end else begin
      state_q <= state_d;
      if (take && plc) begin
        cw_q <= cw; // RULE8
      end
      if (take && speed_map_q) spd_q <= spd_in; // RULE2
      if (take && torque_map_q) trq_q <= trq_in; // RULE2
    end
  end

  // Reply strobe trails the state update by one edge, so the status
  // that it marks already carries the new control word
  reg take_q;
  reg plc_q;
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      take_q <= 1'b0;
      plc_q <= 1'b0;
    end else begin
      take_q <= take; // RULE24
      if (take) begin
        plc_q <= cw[`CW_PLC_CTRL]; // RULE18
      end
    end
  end

  // Fault acknowledge: rising bit 7 held long enough
  // Hold time restarts whenever the bit drops
  reg [31:0] ack_cnt_q;
  reg ack_done_q;
  wire ack_bit = cw_q[`CW_FAULT_ACK];
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      ack_cnt_q <= 32'h0000_0000;
      ack_done_q <= 1'b0;
      fault_reset <= 1'b0;
    end else begin
      fault_reset <= 1'b0;
      if (!ack_bit) begin
        ack_cnt_q <= 32'h0000_0000;
        ack_done_q <= 1'b0;
      end else if (!ack_done_q) begin
        if (ack_cnt_q >= FAULT_ACK_CYCLES - 1) begin // RULE7
          ack_done_q <= 1'b1;
          fault_reset <= 1'b1; // RULE7
        end else begin
          ack_cnt_q <= ack_cnt_q + 32'h0000_0001;
        end
      end
    end
  end

  // Speed and torque derivation
  wire running = (state_q == `ST_OPERATION);

  // Speed path: gate, then magnitude, so the product stays unsigned
  wire signed [15:0] spd_eff = cw_q[`CW_SETPOINT_EN] ? spd_q : 16'sh0000; // RULE6
  wire spd_neg = spd_eff[15];
  wire [16:0] spd_mag = spd_neg ? (17'd0 - {spd_eff[15], spd_eff}) : {1'b0, spd_eff};
  // Truncating product keeps rounding downward
  wire [FREQ_W+16:0] freq_prod = spd_mag * max_frequency; // RULE19

  // Output frequency uses the same scaling as the setpoint
  wire signed [15:0] act = speed_actual_in;
  wire [16:0] act_mag = act[15] ? (17'd0 - {act[15], act}) : {1'b0, act};
  wire [FREQ_W+16:0] ofreq_prod = act_mag * max_frequency; // RULE19

  // Clamp before the enable gate, so re-enabling never sees overrange
  wire signed [15:0] trq_clamped = (trq_q > `TORQUE_MAX) ? `TORQUE_MAX :
                                   (trq_q < `TORQUE_MIN) ? `TORQUE_MIN : trq_q; // RULE21
  // Direction: torque mode treats speed as magnitude only
  wire dir_base = torque_map_q ? 1'b0 : spd_neg; // RULE10

  // Status word built bit by bit; spare bits stay zero
  reg [15:0] status_d;
  always @* begin
    status_d = 16'h0000; // RULE12
    status_d[0] = (state_q != `ST_INHIBIT); // RULE13
    status_d[1] = (state_q == `ST_SWITCHED_ON) || running; // RULE13
    status_d[2] = running; // RULE13
    status_d[3] = fault_active; // RULE14
    status_d[4] = cw_q[`CW_NO_COAST]; // RULE15
    status_d[5] = (state_q != `ST_QUICK_STOP); // RULE16
    status_d[6] = (state_q == `ST_INHIBIT); // RULE13
    status_d[7] = warning_active; // RULE17
    status_d[9] = plc_q && network_op_mode; // RULE18
  end

  // Actual values sign-extended to the slot width
  wire [31:0] speed_ext = {{16{speed_actual_in[15]}}, speed_actual_in};
  wire [31:0] torque_ext = {{16{motor_torque_monitor[15]}}, motor_torque_monitor}; // RULE22
  // One selector per actual-value slot; unknown numbers read zero
  wire [ACT_SLOTS*32-1:0] act_slots;
  genvar g;
  generate
    for (g = 0; g < ACT_SLOTS; g = g + 1) begin : g_act
      wire [15:0] sig_num = actual_map_slot[g*16 +: 16];
      assign act_slots[g*32 +: 32] = (sig_num == `SIG_SPEED_ACT) ? speed_ext :
                                     (sig_num == `SIG_TORQUE_ACT) ? torque_ext : 32'h0000_0000; // RULE2
    end
  endgenerate

  // Drive outputs and status word
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      set_frequency <= {FREQ_W{1'b0}};
      output_frequency <= {FREQ_W{1'b0}};
      run_reverse <= 1'b0;
      start_cmd <= 1'b0;
      output_enable <= 1'b0;
      ramp_freeze <= 1'b0;
      quick_stop_active <= 1'b0;
      torque_command_value <= 16'sh0000;
      homing_start <= 1'b0;
      status_word <= 16'h0000;
      tx_slot_data <= {ACT_SLOTS*32{1'b0}};
      tx_valid <= 1'b0;
    end else begin
      // Frequencies and direction
      set_frequency <= freq_prod[FREQ_W+`SPEED_REF_SHIFT-1:`SPEED_REF_SHIFT]; // RULE20
      output_frequency <= ofreq_prod[FREQ_W+`SPEED_REF_SHIFT-1:`SPEED_REF_SHIFT]; // RULE19
      run_reverse <= dir_base ^ cw_q[`CW_DIR_INV]; // RULE10
      // Drive commands follow the latched state
      start_cmd <= running;
      output_enable <= (state_q == `ST_SWITCHED_ON) || running; // RULE4
      // Freeze ignored when not started
      ramp_freeze <= running && !position_control && !cw_q[`CW_RAMP_RUN]; // RULE5
      quick_stop_active <= (state_q == `ST_QUICK_STOP);
      // Torque in whole percent; scaled to 0.1% downstream
      torque_command_value <= cw_q[`CW_TORQUE_EN] ? trq_clamped : 16'sh0000; // RULE9 RULE22
      homing_start <= cw_q[`CW_HOMING] && position_control && running; // RULE11
      // Reply slots and strobe go out together
      status_word <= status_d; // RULE24
      tx_slot_data <= act_slots;
      tx_valid <= take_q; // RULE24
    end
  end
endmodule // drive_profile_word_interpreter
`default_nettype wire

// ==== testbench/dpwi_checker.sv ====
// Port-level assertions for the word interpreter
`timescale 1ns/10ps
`default_nettype none
module dpwi_checker (
  input wire core_clk,
  input wire rst,
  input wire rx_valid,
  input wire rx_ready,
  input wire tx_valid,
  input wire [15:0] status_word,
  input wire fault_active,
  input wire output_enable,
  input wire start_cmd,
  input wire fault_reset,
  input wire quick_stop_active,
  input wire signed [15:0] torque_command_value
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // Reply timing and spare status bits
  chk_reply_time: assert property (rx_valid && rx_ready |-> ##3 tx_valid)
    else $error("reply late");
  chk_spare_zero: assert property (!status_word[8] && status_word[15:10] == 6'h00)
    else $error("spare status bit set");
  chk_fault_bit: assert property (fault_active [*4] ##1 (fault_active && tx_valid) |=> status_word[3])
    else $error("fault bit low");
  // Clamp holds whatever the master sends
  chk_torque_range: assert property (torque_command_value <= 16'sh0190 && torque_command_value >= -16'sh0190)
    else $error("torque out of range");
  chk_inhibit_off: assert property (status_word[6] |-> !output_enable && !start_cmd)
    else $error("output on while inhibited");
  chk_start_state: assert property (start_cmd |-> status_word[2])
    else $error("start outside operation");
  chk_ack_pulse: assert property (fault_reset |=> !fault_reset)
    else $error("fault reset too long");
  chk_coast_off: assert property (!status_word[4] |-> !output_enable)
    else $error("output on in coast stop");
  chk_quick_flag: assert property (quick_stop_active |-> !status_word[5])
    else $error("quick stop bit high");
  // Main scenarios reached
  cov_operation: cover property (tx_valid && status_word[2]);
  cov_ack: cover property (fault_reset);
  cov_quick: cover property (quick_stop_active);
endmodule // dpwi_checker
bind drive_profile_word_interpreter dpwi_checker u_chk (.core_clk, .rst, .rx_valid, .rx_ready, .tx_valid,
  .status_word, .fault_active, .output_enable, .start_cmd, .fault_reset, .quick_stop_active, .torque_command_value);
`default_nettype wire

// ==== testbench/plc_master_model.sv ====
// Network master model that sends control frames
`timescale 1ns/10ps
`default_nettype none
module plc_master_model (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic send,
  input wire logic [15:0] cw_in,
  input wire logic rx_ready,
  output logic rx_valid,
  output logic [15:0] control_word
);
  // Frame held until taken; stale word inverted so it is never reused
  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      rx_valid <= 1'b0;
      control_word <= 16'h0000;
    end else if (send) begin
      rx_valid <= 1'b1;
      control_word <= cw_in & 16'h3CEF;
    end else if (rx_valid && rx_ready) begin
      rx_valid <= 1'b0;
      control_word <= ~control_word;
    end
  end
endmodule // plc_master_model
`default_nettype wire

// ==== testbench/test_drive_profile_word_interpreter.sv ====
// Self-checking bench for the word interpreter
`timescale 1ns/10ps
`default_nettype none
module test_drive_profile_word_interpreter;
  logic core_clk, rst, send, rx_valid, rx_ready, tx_valid, seen;
  logic net, pos, flt, warn, stopped, rev, start, oe, freeze, qs, homing, frst;
  logic [15:0] cw_in, control_word, status_word, spd, trq, sfreq, ofreq;
  logic signed [15:0] tcmd;
  logic [159:0] map_s;
  logic [223:0] map_a;
  logic [447:0] tx_d;
  int n_fail, cmp_count, cyc;
  wire [319:0] slot_d = {224'h0, 32'h0000_1000, 16'h0000, trq, 16'h0000, spd};
  plc_master_model plc (.core_clk(core_clk), .rst(rst), .send(send), .cw_in(cw_in), .rx_ready(rx_ready),
    .rx_valid(rx_valid), .control_word(control_word));
  drive_profile_word_interpreter #(.FAULT_ACK_CYCLES(10)) dut (.core_clk(core_clk), .rst(rst),
    .rx_valid(rx_valid), .rx_ready(rx_ready), .control_word(control_word), .rx_slot_data(slot_d),
    .setpoint_map_slot(map_s), .actual_map_slot(map_a), .max_frequency(16'h03E8), .network_op_mode(net),
    .position_control(pos), .fault_active(flt), .warning_active(warn), .fault_number_record(16'h0000),
    .motor_stopped(stopped), .speed_actual_in(16'h1000), .motor_torque_monitor(16'h0123),
    .tx_valid(tx_valid), .status_word(status_word), .tx_slot_data(tx_d), .set_frequency(sfreq),
    .run_reverse(rev), .start_cmd(start), .output_enable(oe), .ramp_freeze(freeze),
    .quick_stop_active(qs), .torque_command_value(tcmd), .homing_start(homing), .fault_reset(frst),
    .output_frequency(ofreq));
  // Clock and hang guard; the run needs well under a thousand cycles
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc++;
    if (rst === 1'b1) seen <= 1'b0;
    else if (frst === 1'b1) seen <= 1'b1;
    if (cyc == 3000) begin
      n_fail++;
      results();
    end
  end
  task chk(input [15:0] got, input [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // One frame, then wait for the reply pulse and one settle edge
  task xfer(input [15:0] w);
    int i;
    cw_in = w;
    send = 1'b1;
    @(posedge core_clk);
    #1 send = 1'b0;
    for (i = 0; i < 20 && tx_valid !== 1'b1; i++) @(negedge core_clk);
    chk(tx_valid, 1'b1);
    @(posedge core_clk);
    #1;
  endtask
  task results();
    $display("fails=%0d compares=%0d", n_fail, cmp_count);
    if (n_fail == 0 && cmp_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {rst, net} = 2'b11;
    {send, pos, flt, warn, stopped} = 5'h00;
    cw_in = 16'h0000;
    spd = 16'h2000;
    trq = 16'h01F4;
    // Slot 0 speed, 1 torque, 2 duplicate speed, 3 unknown
    map_s = {10{16'h270F}};
    map_s[63:0] = 64'h1234_0005_0064_0005;
    map_a = {14{16'h270F}};
    map_a[31:0] = 32'h0065_0006;
    repeat (20) @(posedge core_clk);
    #1 rst = 1'b0;
    xfer(16'h0006);
    chk(status_word[6], 1'b1);
    chk(oe, 1'b0);
    xfer(16'h0406);
    chk(status_word, 16'h0231);
    xfer(16'h0407);
    chk(status_word[1], 1'b1);
    chk(oe, 1'b1);
    xfer(16'h0C6F);
    chk(status_word[2], 1'b1);
    chk(start, 1'b1);
    chk(sfreq, 16'h01F4);
    chk(tcmd, 16'h0190);
    chk(tx_d[15:0], 16'h1000);
    chk(tx_d[47:32], 16'h0123);
    chk(tx_d[79:64], 16'h0000);
    chk(ofreq, 16'h00FA);
    trq = 16'hFE0C;
    xfer(16'h0C6F);
    chk(tcmd, 16'hFE70);
    xfer(16'h046F);
    chk(tcmd, 16'h0000);
    xfer(16'h042F);
    chk(sfreq, 16'h0000);
    chk(freeze, 1'b0);
    xfer(16'h044F);
    chk(freeze, 1'b1);
    spd = 16'hE000;
    xfer(16'h0C6F);
    chk(rev, 1'b0);
    xfer(16'h1C6F);
    chk(rev, 1'b1);
    chk(sfreq, 16'h01F4);
    pos = 1'b1;
    xfer(16'h246F);
    chk(homing, 1'b1);
    pos = 1'b0;
    xfer(16'h246F);
    chk(homing, 1'b0);
    warn = 1'b1;
    xfer(16'h046F);
    chk(status_word[7], 1'b1);
    xfer(16'h046B);
    chk(status_word[5], 1'b0);
    chk(qs, 1'b1);
    stopped = 1'b1;
    xfer(16'h046B);
    xfer(16'h0406);
    xfer(16'h0404);
    chk(status_word[4], 1'b0);
    chk(oe, 1'b0);
    net = 1'b0;
    xfer(16'h0406);
    chk(status_word[9], 1'b0);
    {net, flt} = 2'b11;
    xfer(16'h0406);
    chk(status_word[3], 1'b1);
    // Short acknowledge must not clear, a held one must
    xfer(16'h0486);
    xfer(16'h0406);
    chk(seen, 1'b0);
    xfer(16'h0486);
    repeat (30) @(posedge core_clk);
    #1 chk(seen, 1'b1);
    results();
  end
endmodule // test_drive_profile_word_interpreter
`default_nettype wire
